/* src/lpcr_regs.sv */
// Purpose: Register bank and main control logic of the line pump.
// Assumes: Parallel port strobes, address and data are asynchronous pins.
// Notes:   Write captured on strobe rising edge; read data driven while strobe low.
`timescale 1ns/1ps
//
// Contract
// - Writes decode addresses 0, 2, 3; reads decode addresses 0 to 6.
// - Either reset input restores every register to default.
// - Control bits act like the matching hardware pins.
// - Test pulse bit emits isolated pulses every 6 ms.
// - In test pulse mode, data selects sign, frame pulse selects magnitude.
// - Remote unit may start activation when test pulses selected.
// - Back-end loopback in active state loops rx data and frame pulse.
// - Front-end loopback in central mode from inactive activates on own signal.
// - In central mode only, loop number bit selects sync word; loop 2 uses Barker code.
// - Insertion loss bit sends scrambled all-ones pattern.
// - Remote unit may start activation in insertion loss mode.
// - Quiet bit forces deactivated state, transmitter silent.
// - Clearing quiet alone does not reactivate.
// - Remote unit ignores startup signal while quiet; may activate after.
// - Central mode, inactive, not quiet: level request starts activation.
// - Write data captured on write strobe rising edge with select low.
// - Read strobe low drives selected register onto data bus.
module lpcr_regs
   import lpcr_pkg::*;
#(
   parameter int PULSE_GAP_CYC = LPCR_PULSE_GAP_CYC
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic       i_primary_reset_input_n,
   input  wire logic       i_secondary_reset_input_n,
   input  wire logic       i_device_select_n,
   input  wire logic       i_read_n,
   input  wire logic       i_write_n,
   input  wire logic [3:0] i_register_address_lines,
   input  wire logic [7:0] i_data,
   output logic      [7:0] o_data,
   output logic      [7:0] o_data_oe,
   input  wire logic       i_central_office_unit,
   input  wire logic       i_startup_signal,
   input  wire logic       i_activation_done,
   input  wire logic       i_activation_failed,
   input  wire logic       i_tx_data,
   input  wire logic       i_tx_frame_pulse,
   input  wire logic       i_rx_data,
   input  wire logic       i_rx_frame_pulse,
   input  wire logic [7:0] i_main_status,
   input  wire logic [7:0] i_receiver_gain_word,
   input  wire logic [7:0] i_noise_margin,
   input  wire logic [7:0] i_coefficient_low_byte,
   input  wire logic [7:0] i_coefficient_high_byte,
   input  wire logic [7:0] i_receiver_agc_step_gain,
   output logic      [7:0] o_main_control,
   output logic      [7:0] o_interrupt_mask,
   output logic      [7:0] o_coefficient_select,
   output logic      [1:0] o_line_state,
   output logic            o_tx_enable,
   output logic            o_tx_data,
   output logic            o_tx_frame_pulse,
   output logic            o_test_pulse,
   output logic            o_test_sign,
   output logic            o_test_magnitude,
   output logic            o_all_ones_pattern,
   output logic            o_loop2_sync_word,
   output logic            o_self_sync
);
   // ==========================================================
   // Pin synchronisers
   localparam int SYNC_W = 19;
   logic [SYNC_W-1:0] pins_async;
   logic [SYNC_W-1:0] pins;
   // Active-low pins enter inverted so the synchroniser reset value is their idle level
   assign pins_async = {~i_primary_reset_input_n, ~i_secondary_reset_input_n, ~i_device_select_n,
                        ~i_read_n, ~i_write_n, i_register_address_lines, i_data,
                        i_central_office_unit, i_startup_signal};

   lpcr_sync #(.WIDTH(SYNC_W)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (pins_async),
      .o_sync    (pins)
   );

   logic       rst1_n;
   logic       rst2_n;
   logic       sel_n;
   logic       rd_n;
   logic       wr_n;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       co_mode;
   logic       startup;
   assign rst1_n  = !pins[18];
   assign rst2_n  = !pins[17];
   assign sel_n   = !pins[16];
   assign rd_n    = !pins[15];
   assign wr_n    = !pins[14];
   assign addr    = pins[13:10];
   assign wdata   = pins[9:2];
   assign co_mode = pins[1];
   assign startup = pins[0];

   // Synchronous soft reset from either reset pin
   logic soft_rst;
   assign soft_rst = !rst1_n || !rst2_n;

   // ==========================================================
   // Write port
   logic       wr_n_d;
   logic [7:0] main_control;
   logic [7:0] interrupt_mask;
   logic [7:0] coefficient_select;
   logic       wr_n_next_d;
   logic [7:0] next_main_control;
   logic [7:0] next_interrupt_mask;
   logic [7:0] next_coefficient_select;
   logic       wr_rise;
   assign wr_rise = wr_n && !wr_n_d && !sel_n;

   always_comb begin
      next_main_control       = main_control;
      next_interrupt_mask     = interrupt_mask;
      next_coefficient_select = coefficient_select;
      wr_n_next_d             = wr_n;
      if (soft_rst) begin
         next_main_control       = LPCR_MAIN_RESET;
         next_interrupt_mask     = LPCR_MASK_RESET;
         next_coefficient_select = LPCR_COEF_RESET;
      end else if (wr_rise) begin
         case (addr)
            LPCR_ADDR_MAIN: next_main_control       = wdata;
            LPCR_ADDR_MASK: next_interrupt_mask     = wdata;
            LPCR_ADDR_COEF: next_coefficient_select = wdata;
            default:        next_main_control       = main_control;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_n_d             <= 1'b1;
         main_control       <= LPCR_MAIN_RESET;
         interrupt_mask     <= LPCR_MASK_RESET;
         coefficient_select <= LPCR_COEF_RESET;
      end else begin
         wr_n_d             <= wr_n_next_d;
         main_control       <= next_main_control;
         interrupt_mask     <= next_interrupt_mask;
         coefficient_select <= next_coefficient_select;
      end
   end

   // ==========================================================
   // Read port
   logic [7:0] next_data;
   logic [7:0] next_data_oe;

   always_comb begin
      next_data_oe = {8{!sel_n && !rd_n}};
      case (addr)
         LPCR_ADDR_MAIN:     next_data = i_main_status;
         LPCR_ADDR_GAIN:     next_data = i_receiver_gain_word;
         LPCR_ADDR_MASK:     next_data = i_noise_margin;
         LPCR_ADDR_COEF:     next_data = i_coefficient_low_byte;
         LPCR_ADDR_COEF_HI:  next_data = i_coefficient_high_byte;
         LPCR_ADDR_ACT_STAT: next_data = {6'h00, o_line_state};
         LPCR_ADDR_AGC_STEP: next_data = i_receiver_agc_step_gain;
         default:            next_data = LPCR_RSVD_READ;
      endcase
   end

   // ==========================================================
   // Control bit decode
   logic test_en;
   logic back_loop;
   logic front_loop;
   logic loop_num;
   logic ins_loss;
   logic quiet;
   logic act_req;
   assign test_en    = main_control[LPCR_B_TEST_PULSE];
   assign back_loop  = main_control[LPCR_B_BACK_LOOP];
   assign front_loop = main_control[LPCR_B_FRONT_LOOP];
   assign loop_num   = main_control[LPCR_B_LOOP_NUM];
   assign ins_loss   = main_control[LPCR_B_INS_LOSS];
   assign quiet      = main_control[LPCR_B_QUIET];
   assign act_req    = main_control[LPCR_B_ACT_REQ];

   // ==========================================================
   // Line state machine
   lpcr_line_state_t state;
   lpcr_line_state_t next_state;
   logic             start_act;

   always_comb begin
      if (co_mode) begin
         start_act = act_req || front_loop;
      end else begin
         start_act = startup || test_en || ins_loss;
      end
      next_state = state;
      case (state)
         LPCR_INACTIVE:   if (!quiet && start_act) begin
            next_state = LPCR_ACTIVATING;
         end
         LPCR_ACTIVATING: if (i_activation_failed) begin
            next_state = LPCR_INACTIVE;
         end else if (i_activation_done) begin
            next_state = LPCR_ACTIVE;
         end
         LPCR_ACTIVE:     next_state = LPCR_ACTIVE;
         default:         next_state = LPCR_INACTIVE;
      endcase
      if (quiet || soft_rst) begin
         next_state = LPCR_INACTIVE;
      end
   end

   // ==========================================================
   // Test pulse timer
   logic [31:0] gap_cnt;
   logic [31:0] next_gap_cnt;
   logic        next_test_pulse;

   always_comb begin
      next_gap_cnt    = 32'h0000_0000;
      next_test_pulse = 1'b0;
      if (test_en) begin
         if (gap_cnt >= 32'(PULSE_GAP_CYC - 1)) begin
            next_test_pulse = 1'b1;
         end else begin
            next_gap_cnt = gap_cnt + 32'h0000_0001;
         end
      end
   end

   // ==========================================================
   // Transmit path and status outputs
   logic next_tx_enable;
   logic next_tx_data;
   logic next_tx_frame_pulse;
   logic active;
   assign active = (state == LPCR_ACTIVE);

   always_comb begin
      next_tx_enable      = !quiet && (state != LPCR_INACTIVE || test_en || ins_loss);
      next_tx_data        = i_tx_data;
      next_tx_frame_pulse = i_tx_frame_pulse;
      if (back_loop && active) begin
         next_tx_data        = i_rx_data;
         next_tx_frame_pulse = i_rx_frame_pulse;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state                <= LPCR_INACTIVE;
         gap_cnt              <= 32'h0000_0000;
         o_test_pulse         <= 1'b0;
         o_test_sign          <= 1'b0;
         o_test_magnitude     <= 1'b0;
         o_data               <= LPCR_RSVD_READ;
         o_data_oe            <= 8'h00;
         o_tx_enable          <= 1'b0;
         o_tx_data            <= 1'b0;
         o_tx_frame_pulse     <= 1'b0;
         o_all_ones_pattern   <= 1'b0;
         o_loop2_sync_word    <= 1'b0;
         o_self_sync          <= 1'b0;
         o_line_state         <= 2'h0;
         o_main_control       <= LPCR_MAIN_RESET;
         o_interrupt_mask     <= LPCR_MASK_RESET;
         o_coefficient_select <= LPCR_COEF_RESET;
      end else begin
         state                <= next_state;
         gap_cnt              <= next_gap_cnt;
         o_test_pulse         <= next_test_pulse;
         o_test_sign          <= i_tx_data;
         o_test_magnitude     <= i_tx_frame_pulse;
         o_data               <= next_data;
         o_data_oe            <= next_data_oe;
         o_tx_enable          <= next_tx_enable;
         o_tx_data            <= next_tx_data;
         o_tx_frame_pulse     <= next_tx_frame_pulse;
         o_all_ones_pattern   <= ins_loss && !quiet;
         o_loop2_sync_word    <= co_mode && loop_num;
         o_self_sync          <= co_mode && front_loop;
         o_line_state         <= next_state;
         o_main_control       <= next_main_control;
         o_interrupt_mask     <= next_interrupt_mask;
         o_coefficient_select <= next_coefficient_select;
      end
   end
endmodule : lpcr_regs

/* common/lpcr_pkg.sv */
// Purpose: Constants for the line pump control register bank.
// Assumes: Four-bit register address, eight-bit data port.
// Notes:   Offsets, field positions and reset values live here only.
package lpcr_pkg;
   // ==========================================================
   // Register addresses
   localparam logic [3:0] LPCR_ADDR_MAIN        = 4'h0;
   localparam logic [3:0] LPCR_ADDR_GAIN        = 4'h1;
   localparam logic [3:0] LPCR_ADDR_MASK        = 4'h2;
   localparam logic [3:0] LPCR_ADDR_COEF        = 4'h3;
   localparam logic [3:0] LPCR_ADDR_COEF_HI     = 4'h4;
   localparam logic [3:0] LPCR_ADDR_ACT_STAT    = 4'h5;
   localparam logic [3:0] LPCR_ADDR_AGC_STEP    = 4'h6;
   // ==========================================================
   // Reset values and reserved read value
   localparam logic [7:0] LPCR_MAIN_RESET       = 8'h00;
   localparam logic [7:0] LPCR_MASK_RESET       = 8'h00;
   localparam logic [7:0] LPCR_COEF_RESET       = 8'h00;
   localparam logic [7:0] LPCR_RSVD_READ        = 8'h00;
   // ==========================================================
   // Main control bit positions
   localparam int LPCR_B_TEST_PULSE  = 7;
   localparam int LPCR_B_BACK_LOOP   = 6;
   localparam int LPCR_B_FRONT_LOOP  = 5;
   localparam int LPCR_B_RPT_SIDE    = 4;
   localparam int LPCR_B_LOOP_NUM    = 3;
   localparam int LPCR_B_INS_LOSS    = 2;
   localparam int LPCR_B_QUIET       = 1;
   localparam int LPCR_B_ACT_REQ     = 0;
   // ==========================================================
   // Timing: test pulse spacing
   localparam int LPCR_CLK_HZ          = 50_000_000;
   localparam int LPCR_PULSE_GAP_MS    = 6;
   localparam int LPCR_PULSE_GAP_CYC   = LPCR_CLK_HZ / 1000 * LPCR_PULSE_GAP_MS;
   // ==========================================================
   // Line state
   typedef enum logic [1:0] {
      LPCR_INACTIVE,
      LPCR_ACTIVATING,
      LPCR_ACTIVE
   } lpcr_line_state_t;
endpackage : lpcr_pkg

/* src/lpcr_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous pin inputs.
// Assumes: Destination clock is i_clk_sys.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module lpcr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= '0;
         o_sync <= '0;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule : lpcr_sync

/* sim/lpcr_regs_checker.sv */
// Purpose: Port-level assertions for the line pump register bank.
// Assumes: Host holds strobes at least six clocks; pins stable meanwhile.
// Notes:   Pulse period is measured with a helper counter.
`timescale 1ns/1ps
module lpcr_regs_checker
   import lpcr_pkg::*;
#(
   parameter int PULSE_GAP_CYC = LPCR_PULSE_GAP_CYC
) (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_n,
   input wire logic       i_primary_reset_input_n,
   input wire logic       i_secondary_reset_input_n,
   input wire logic       i_device_select_n,
   input wire logic       i_read_n,
   input wire logic [3:0] i_register_address_lines,
   input wire logic       i_central_office_unit,
   input wire logic       i_rx_data,
   input wire logic [7:0] i_receiver_gain_word,
   input wire logic [7:0] o_data,
   input wire logic [7:0] o_data_oe,
   input wire logic [7:0] o_main_control,
   input wire logic [1:0] o_line_state,
   input wire logic       o_tx_enable,
   input wire logic       o_tx_data,
   input wire logic       o_test_pulse,
   input wire logic       o_loop2_sync_word
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   int   gap_cnt;
   logic seen;
   // ==========================================================
   // Test pulse period counter
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap_cnt <= 0;
         seen    <= 1'b0;
      end else begin
         gap_cnt <= o_test_pulse ? 1 : gap_cnt + 1;
         seen    <= (seen | o_test_pulse) & o_main_control[7] & ~o_main_control[1];
      end
   end
   // ==========================================================
   // Sequences
   sequence gain_read;
      (!i_device_select_n && !i_read_n && i_register_address_lines == 4'h1
       && $stable(i_receiver_gain_word))[*6];
   endsequence
   sequence rsvd_read;
      (!i_device_select_n && !i_read_n && i_register_address_lines >= 4'h7)[*6];
   endsequence
   sequence back_loop_on;
      (o_line_state == 2'h2 && o_main_control[6]) ##1 o_line_state == 2'h2;
   endsequence
   // ==========================================================
   // Assertions
   pin_reset_a: assert property (
      ((!i_primary_reset_input_n)[*6] or (!i_secondary_reset_input_n)[*6]) |->
      o_main_control == 8'h00 && o_line_state == 2'h0) else $error("pin reset kept state");
   pulse_period_a: assert property (
      o_test_pulse && seen |-> gap_cnt == PULSE_GAP_CYC) else $error("test pulse spacing wrong");
   back_loop_a: assert property (
      back_loop_on |-> o_tx_data == $past(i_rx_data)) else $error("loopback data wrong");
   loop_word_a: assert property (
      (i_central_office_unit && !o_main_control[1] && $stable(o_main_control[3]))[*4] |->
      o_loop2_sync_word == o_main_control[3]) else $error("sync word select wrong");
   quiet_force_a: assert property (
      $rose(o_main_control[1]) |-> ##[0:2] (o_line_state == 2'h0 && !o_tx_enable))
      else $error("quiet did not deactivate");
   quiet_release_a: assert property (
      $fell(o_main_control[1]) && o_main_control == 8'h00 && i_central_office_unit |->
      (o_line_state == 2'h0)[*4]) else $error("quiet release reactivated");
   act_request_a: assert property (
      o_line_state == 2'h0 && o_main_control[1:0] == 2'b01 && i_central_office_unit &&
      i_primary_reset_input_n && i_secondary_reset_input_n |-> ##[1:3] o_line_state != 2'h0)
      else $error("request did not activate");
   gain_read_a: assert property (
      gain_read |-> o_data == i_receiver_gain_word && o_data_oe == 8'hFF) else $error("read data wrong");
   rsvd_read_a: assert property (
      rsvd_read |-> o_data == LPCR_RSVD_READ) else $error("reserved read not constant");
endmodule : lpcr_regs_checker

bind lpcr_regs lpcr_regs_checker #(.PULSE_GAP_CYC(PULSE_GAP_CYC)) u_checker (.*);

/* sim/lpcr_host_model.sv */
// Purpose: Host processor on the parallel register port.
// Assumes: Write strobe held six clocks, read strobe nine; driven at falling edge.
// Notes:   Idle data lines show the inverse of the last word.
`timescale 1ns/1ps
module lpcr_host_model (
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_bus,
   output logic            o_sel_n,
   output logic            o_rd_n,
   output logic            o_wr_n,
   output logic      [3:0] o_addr,
   output logic      [7:0] o_wdata
);
   initial begin
      o_sel_n = 1'b1;
      o_rd_n  = 1'b1;
      o_wr_n  = 1'b1;
      o_addr  = 4'h0;
      o_wdata = 8'h00;
   end
   // ==========================================================
   // Bus cycles
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      o_sel_n = 1'b0;
      o_addr  = a;
      o_wdata = d;
      o_wr_n  = 1'b0;
      repeat (6) @(negedge i_clk_sys);
      o_wr_n  = 1'b1;
      repeat (6) @(negedge i_clk_sys);
      o_sel_n = 1'b1;
      o_wdata = ~d;
      repeat (3) @(negedge i_clk_sys);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge i_clk_sys);
      o_sel_n = 1'b0;
      o_addr  = a;
      o_rd_n  = 1'b0;
      repeat (8) @(negedge i_clk_sys);
      d = i_bus;
      @(negedge i_clk_sys);
      o_rd_n  = 1'b1;
      o_sel_n = 1'b1;
      repeat (5) @(negedge i_clk_sys);
   endtask : rd
endmodule : lpcr_host_model

/* sim/line_pump_control_registers_tb.sv */
// Purpose: Self-checking bench for the line pump register bank.
// Assumes: Pulse gap shortened to GAP clocks.
// Notes:   Row table for writes, address sweep for reads, then hand-written cases.
`timescale 1ns/1ps
module line_pump_control_registers_tb;
   import lpcr_pkg::*;
   localparam int GAP = 20;
   typedef struct {logic [3:0] a; logic [7:0] d, mc, im, cs;} lpcr_row_t;
   logic       i_clk_sys = 1'b0, i_rst_n = 1'b0, i_primary_reset_input_n = 1'b1, i_secondary_reset_input_n = 1'b1;
   logic       i_central_office_unit = 1'b1, i_startup_signal = 1'b0, i_activation_done = 1'b0;
   logic       i_activation_failed = 1'b0, i_tx_data = 1'b0, i_tx_frame_pulse = 1'b0, i_rx_data = 1'b0;
   logic       i_rx_frame_pulse = 1'b0, i_device_select_n, i_read_n, i_write_n;
   logic [3:0] i_register_address_lines;
   logic [7:0] i_data, o_data, o_data_oe, o_main_control, o_interrupt_mask, o_coefficient_select, rv;
   logic [7:0] i_main_status = 8'hA1, i_receiver_gain_word = 8'hB2, i_noise_margin = 8'hC3;
   logic [7:0] i_coefficient_low_byte = 8'hD4, i_coefficient_high_byte = 8'hE5, i_receiver_agc_step_gain = 8'h96;
   logic [1:0] o_line_state;
   logic       o_tx_enable, o_tx_data, o_tx_frame_pulse, o_test_pulse, o_test_sign, o_test_magnitude;
   logic       o_all_ones_pattern, o_loop2_sync_word, o_self_sync;
   int         error_cnt = 0, checked = 0, n;
   lpcr_row_t  rows [7] = '{'{4'h0, 8'h08, 8'h08, 8'h00, 8'h00}, '{4'h2, 8'h3D, 8'h08, 8'h3D, 8'h00},
                           '{4'h3, 8'h1A, 8'h08, 8'h3D, 8'h1A}, '{4'h1, 8'hFF, 8'h08, 8'h3D, 8'h1A},
                           '{4'h4, 8'h55, 8'h08, 8'h3D, 8'h1A}, '{4'hF, 8'hAA, 8'h08, 8'h3D, 8'h1A},
                           '{4'h0, 8'h00, 8'h00, 8'h3D, 8'h1A}};
   lpcr_regs #(.PULSE_GAP_CYC(GAP)) u_dut (.*);
   lpcr_host_model u_host (.i_clk_sys, .i_bus(o_data), .o_sel_n(i_device_select_n), .o_rd_n(i_read_n),
                           .o_wr_n(i_write_n), .o_addr(i_register_address_lines), .o_wdata(i_data));
   initial begin
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   // ==========================================================
   // Helpers
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic logic [7:0] exp_rd(input logic [3:0] a);
      case (a)
         4'h0: return i_main_status;
         4'h1: return i_receiver_gain_word;
         4'h2: return i_noise_margin;
         4'h3: return i_coefficient_low_byte;
         4'h4: return i_coefficient_high_byte;
         4'h6: return i_receiver_agc_step_gain;
         default: return 8'h00;
      endcase
   endfunction : exp_rd
   task automatic tally_and_finish;
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      error_cnt++;
      tally_and_finish();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      chk("mc_reset", o_main_control, LPCR_MAIN_RESET);
      foreach (rows[i]) begin
         u_host.wr(rows[i].a, rows[i].d);
         chk("main_control", o_main_control, rows[i].mc);
         chk("interrupt_mask", o_interrupt_mask, rows[i].im);
         chk("coef_select", o_coefficient_select, rows[i].cs);
         chk("loop2", o_loop2_sync_word, rows[i].mc[3]);
      end
      for (int a = 0; a < 16; a++) begin
         u_host.rd(a[3:0], rv);
         chk("read", rv, exp_rd(a[3:0]));
      end
      for (int k = 0; k < 2; k++) begin
         u_host.wr(4'h2, 8'h3C);
         u_host.wr(4'h3, 8'h1A);
         if (k == 0) i_primary_reset_input_n = 1'b0;
         else i_secondary_reset_input_n = 1'b0;
         repeat (8) @(negedge i_clk_sys);
         chk("mask_pin_reset", o_interrupt_mask, 8'h00);
         chk("coef_pin_reset", o_coefficient_select, 8'h00);
         i_primary_reset_input_n = 1'b1;
         i_secondary_reset_input_n = 1'b1;
         repeat (4) @(negedge i_clk_sys);
      end
      u_host.wr(4'h0, 8'h01);
      chk("activating", o_line_state, 2'h1);
      i_activation_done = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      i_activation_done = 1'b0;
      chk("active", o_line_state, 2'h2);
      chk("tx_on", o_tx_enable, 1'b1);
      u_host.wr(4'h0, 8'h41);
      for (int v = 0; v < 2; v++) begin
         i_rx_data = v[0];
         i_rx_frame_pulse = v[0];
         i_tx_data = ~v[0];
         i_tx_frame_pulse = ~v[0];
         repeat (3) @(negedge i_clk_sys);
         chk("loop_data", o_tx_data, v[0]);
         chk("loop_frame", o_tx_frame_pulse, v[0]);
      end
      u_host.wr(4'h0, 8'h43);
      chk("quiet_state", o_line_state, 2'h0);
      chk("quiet_tx", o_tx_enable, 1'b0);
      u_host.wr(4'h0, 8'h00);
      repeat (10) @(negedge i_clk_sys);
      chk("no_reactivate", o_line_state, 2'h0);
      u_host.wr(4'h0, 8'h24);
      chk("all_ones", o_all_ones_pattern, 1'b1);
      chk("self_sync", o_self_sync, 1'b1);
      chk("front_loop_act", o_line_state, 2'h1);
      i_central_office_unit = 1'b0;
      i_tx_data = 1'b1;
      i_tx_frame_pulse = 1'b0;
      u_host.wr(4'h0, 8'h80);
      for (int c = 0; c < 4 * GAP && !o_test_pulse; c++) @(negedge i_clk_sys);
      n = 0;
      repeat (5 * GAP) begin
         @(negedge i_clk_sys);
         n += o_test_pulse;
      end
      chk("pulses", n[7:0], 8'h05);
      chk("sign", o_test_sign, 1'b1);
      chk("magnitude", o_test_magnitude, 1'b0);
      i_startup_signal = 1'b1;
      u_host.wr(4'h0, 8'h02);
      chk("quiet_ignores_start", o_line_state, 2'h0);
      u_host.wr(4'h0, 8'h00);
      chk("start_after_quiet", o_line_state, 2'h1);
      i_startup_signal = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      i_activation_failed = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      i_activation_failed = 1'b0;
      chk("failed_inactive", o_line_state, 2'h0);
      tally_and_finish();
   end
endmodule : line_pump_control_registers_tb
